/* src/fph_policer.sv */
// Frame policer hierarchy with its register file
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE_01 - At most one classifier-action policer meters a frame, inner or outer.
// RULE_02 - Inner position flag places that policer after service policing and statistics.
// RULE_03 - Classifier, port, storm and BCAST_UCAST_MCAST_POLICER use one bucket; service and bundle use two.
// RULE_04 - BCAST_UCAST_MCAST_POLICER buckets come in threes: broadcast, unicast, multicast.
// RULE_05 - Classifier, port and storm rates step in 25,040 bit/s units.
// RULE_06 - Fine timescale: BCAST_UCAST_MCAST_POLICER, service, bundle up to 32 Mbps in 16 kbps steps.
// RULE_07 - Coarse timescale: same policers up to 10 Gbps in 8 Mbps steps.
// RULE_08 - Non-service frames with zero indexes may use a service policer as queue policer.
// RULE_09 - Global enable switches queue policing; per-port setting picks the policer.
// RULE_10 - Service frames take their bundle policer from the service table.
// RULE_11 - Non-service frames may use a per-port bundle policer when globally enabled.
// RULE_12 - Per-service pipeline point gates BCAST_UCAST_MCAST_POLICER, service and bundle policers; none disables it.
// RULE_13 - Service statistics follow the service colour even if dropped later.
// RULE_14 - Every bucket adds a signed byte adjustment of -64 to +63.
// RULE_15 - Thirty-two classifier-action policers with own settings.
// RULE_16 - Eight storm policers with own settings.
// RULE_17 - Port policers have a hysteresis threshold for flow control mode.
// RULE_18 - Policer events latch into sticky flags, service events in their own set.
// RULE_19 - Drop precedence above colour-aware level counts yellow; level three is blind.
// RULE_20 - Coupled second bucket holds committed plus excess, so green charges both.
// RULE_21 - Buckets drain at rate, fill by length; over threshold means nonconforming.
module fph_policer
  import fph_pkg::*;
#(
  parameter int NUM_ACL      = 32,
  parameter int NUM_STORM    = 8,
  parameter int NUM_PORTS    = 4,
  parameter int NUM_SERVICES = 8,
  parameter int NUM_SERVICE_DUAL_BUCKET     = 8,
  parameter int NUM_BUNDLE_DUAL_BUCKET     = 4,
  parameter int SLB_TICK_CYCLES  = SLB_TICK_CYC,
  parameter int FINE_TICK_CYCLES = FINE_TICK_CYC,
  localparam int ACL_W = $clog2(NUM_ACL),
  localparam int STM_W = $clog2(NUM_STORM),
  localparam int PRT_W = $clog2(NUM_PORTS),
  localparam int SVC_W = $clog2(NUM_SERVICES),
  localparam int SD_W  = $clog2(NUM_SERVICE_DUAL_BUCKET),
  localparam int BD_W  = $clog2(NUM_BUNDLE_DUAL_BUCKET)
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // Register port
  input  wire logic [9:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rd_data_o,
  // Frame from the classifier
  input  wire logic             frame_valid_i,
  input  wire logic [LEN_W-1:0] frame_len_i,
  input  wire logic [PRT_W-1:0] frame_port_i,
  input  wire logic [SVC_W-1:0] service_index_i,
  input  wire logic [SD_W-1:0]  service_policer_index_i,
  input  wire logic [1:0]       frame_dp_i,
  input  wire logic [1:0]       frame_cast_i,
  input  wire logic [1:0]       frame_stage_i,
  input  wire logic             acl_valid_i,
  input  wire logic [ACL_W-1:0] acl_index_i,
  input  wire logic             inner_position_flag_i,
  input  wire logic             storm_valid_i,
  input  wire logic [STM_W-1:0] storm_index_i,
  // Verdict and statistics
  output logic                  res_valid_o,
  output logic                  res_drop_o,
  output logic      [1:0]       res_colour_o,
  output logic                  svc_stat_valid_o,
  output logic                  svc_stat_yellow_o,
  output logic                  svc_stat_red_o,
  output logic [NUM_PORTS-1:0]  port_flow_ctrl_o
);
  localparam int STORM_B = NUM_ACL;
  localparam int PORT_B  = STORM_B + NUM_STORM;
  localparam int BUM_B   = PORT_B + NUM_PORTS;
  localparam int DLB_B   = BUM_B + 3 * NUM_SERVICES;
  localparam int NUM_DLB = NUM_SERVICE_DUAL_BUCKET + NUM_BUNDLE_DUAL_BUCKET;
  localparam int NB      = DLB_B + 2 * NUM_DLB;
  localparam int BK_W    = $clog2(NB);
  localparam int DL_W    = $clog2(NUM_DLB);

  // Registers
  logic [1:0]       ctrl_reg;
  logic [STK_W-1:0] sticky_reg;
  logic [2:0]       dlb_sticky_reg;
  logic [1:0]       svc_pp_reg [NUM_SERVICES];
  logic [BD_W-1:0]  svc_bd_reg [NUM_SERVICES];
  logic [SD_W-1:0]  port_q_reg [NUM_PORTS];
  logic [BD_W-1:0]  port_bd_reg [NUM_PORTS];
  logic [1:0]       cal_reg [NUM_DLB];
  logic             cpl_reg [NUM_DLB];
  logic [15:0]      slb_cnt_reg;
  logic [15:0]      fine_cnt_reg;
  logic [15:0]      coarse_cnt_reg;
  logic             slb_tick_reg;
  logic             fine_tick_reg;
  logic             coarse_tick_reg;

  // Bucket array wiring
  logic [31:0]      cfg0 [NB];
  logic [31:0]      cfg1 [NB];
  logic [NB-1:0]    over;
  logic [NB-1:0]    below2;
  logic [NB-1:0]    charge;
  logic [NB-1:0]    bk_wr;
  logic [9:0]       bk_off;

  assign bk_off = addr_i - ADDR_BKT_BASE;

  // Drain enables, one per rate step
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      slb_cnt_reg    <= 16'h0000;
      fine_cnt_reg   <= 16'h0000;
      coarse_cnt_reg <= 16'h0000;
      slb_tick_reg    <= 1'b0;
      fine_tick_reg   <= 1'b0;
      coarse_tick_reg <= 1'b0;
    end else begin
      slb_tick_reg    <= slb_cnt_reg == 16'(SLB_TICK_CYCLES - 1); // RULE_05
      fine_tick_reg   <= fine_cnt_reg == 16'(FINE_TICK_CYCLES - 1); // RULE_06
      coarse_tick_reg <= coarse_cnt_reg == 16'(COARSE_TICK_CYC - 1); // RULE_07
      // Wrap on the terminal count itself so each tick period is exactly the step
      slb_cnt_reg    <= (slb_cnt_reg == 16'(SLB_TICK_CYCLES - 1)) ? 16'h0000 : slb_cnt_reg + 16'h0001;
      fine_cnt_reg   <= (fine_cnt_reg == 16'(FINE_TICK_CYCLES - 1)) ? 16'h0000 : fine_cnt_reg + 16'h0001;
      coarse_cnt_reg <= (coarse_cnt_reg == 16'(COARSE_TICK_CYC - 1)) ? 16'h0000 : coarse_cnt_reg + 16'h0001;
    end
  end

  // Buckets below BUM_B are single-rate policers; the rest use timescales
  for (genvar b = 0; b < NB; b++) begin : g_bkt
    assign bk_wr[b] = wr_i && (addr_i >= ADDR_BKT_BASE) && (bk_off[9:1] == 9'(b));
    fph_bucket #(
      .SLB_MODE (b < BUM_B)
    ) u_bkt (
      .mclk_i        (mclk_i),
      .reset_i       (reset_i),
      .slb_tick_i    (slb_tick_reg),
      .fine_tick_i   (fine_tick_reg),
      .coarse_tick_i (coarse_tick_reg),
      .wr_i          (bk_wr[b]),
      .wsel_i        (bk_off[0]),
      .wdata_i       (wdata_i),
      .cfg0_o        (cfg0[b]),
      .cfg1_o        (cfg1[b]),
      .charge_i      (charge[b]),
      .len_i         (frame_len_i),
      .over_o        (over[b]),
      .below2_o      (below2[b])
    ); // RULE_03 RULE_15 RULE_16
  end

  // Policer selection
  logic [BK_W-1:0] acl_bk, storm_bk, port_bk, bum_bk, sd_bk, bd_bk;
  logic [SD_W-1:0] sd_idx;
  logic [BD_W-1:0] bd_idx;
  logic [DL_W-1:0] bd_dl;
  logic [1:0]      cast_sel;
  logic            svc_frame, pp_ok, sd_use, bd_use;

  assign svc_frame = service_index_i != '0;
  // Undefined cast code 3 meters as multicast
  assign cast_sel = (frame_cast_i == 2'h3) ? 2'h2 : frame_cast_i;
  assign pp_ok = (svc_pp_reg[service_index_i] == PP_NONE)
              || (frame_stage_i < svc_pp_reg[service_index_i]); // RULE_12
  assign sd_use = pp_ok && ((service_policer_index_i != '0)
               || (!svc_frame && ctrl_reg[CTRL_DQ_BIT])); // RULE_08 RULE_09
  assign sd_idx = (service_policer_index_i != '0) ? service_policer_index_i
                : port_q_reg[frame_port_i]; // RULE_09
  assign bd_use = pp_ok && (svc_frame || ctrl_reg[CTRL_PB_BIT]); // RULE_11
  assign bd_idx = svc_frame ? svc_bd_reg[service_index_i]
                : port_bd_reg[frame_port_i]; // RULE_10 RULE_11
  assign bd_dl    = DL_W'(NUM_SERVICE_DUAL_BUCKET + int'(bd_idx));
  assign acl_bk   = BK_W'(int'(acl_index_i));
  assign storm_bk = BK_W'(STORM_B + int'(storm_index_i));
  assign port_bk  = BK_W'(PORT_B + int'(frame_port_i));
  assign bum_bk   = BK_W'(BUM_B + 3 * int'(service_index_i) + int'(cast_sel)); // RULE_04
  assign sd_bk    = BK_W'(DLB_B + 2 * int'(sd_idx));
  assign bd_bk    = BK_W'(DLB_B + 2 * int'(bd_dl));

  // Two-bucket colour: committed bucket for green, excess bucket for yellow
  function automatic fph_colour_type dlb_colour(input logic in_yellow,
                                                input logic over0,
                                                input logic over1);
    if (!in_yellow && !over0) begin
      dlb_colour = COL_GREEN;
    end else if (!over1) begin
      dlb_colour = COL_YELLOW;
    end else begin
      dlb_colour = COL_RED;
    end
  endfunction : dlb_colour

  // Hierarchy walk: outer ACL, BCAST_UCAST_MCAST_POLICER, service, inner ACL, bundle, port, storm
  fph_colour_type sd_col, bd_col, fin_col;
  logic acl_over, outer_drop, bum_drop, inner_drop, port_drop, storm_drop;
  logic p1, p2, p3, p4, p5, p6, p7, sd_yin, bd_yin;

  assign acl_over   = frame_valid_i && acl_valid_i && over[acl_bk];
  assign outer_drop = acl_over && !inner_position_flag_i; // RULE_01 RULE_02
  assign p1 = frame_valid_i && !outer_drop;
  assign bum_drop = p1 && pp_ok && over[bum_bk]; // RULE_12
  assign p2 = p1 && !bum_drop;
  assign sd_yin = frame_dp_i > cal_reg[DL_W'(sd_idx)]; // RULE_19
  assign sd_col = sd_use ? dlb_colour(sd_yin, over[sd_bk], over[sd_bk + 1'b1]) : COL_GREEN;
  assign p3 = p2 && (sd_col != COL_RED);
  assign inner_drop = p3 && acl_over && inner_position_flag_i; // RULE_01 RULE_02
  assign p4 = p3 && !inner_drop;
  assign bd_yin = (sd_col == COL_YELLOW) || (frame_dp_i > cal_reg[bd_dl]); // RULE_19
  assign bd_col = bd_use ? dlb_colour(bd_yin, over[bd_bk], over[bd_bk + 1'b1]) : sd_col;
  assign p5 = p4 && (bd_col != COL_RED);
  // A port in flow control mode never drops; it pauses the link instead
  assign port_drop = p5 && over[port_bk] && !cfg1[port_bk][FC_BIT]; // RULE_17
  assign p6 = p5 && !port_drop;
  assign storm_drop = p6 && storm_valid_i && over[storm_bk];
  assign p7 = p6 && !storm_drop;
  assign fin_col = (p4 && bd_use) ? bd_col : sd_col;

  // Only conforming frames that reach a bucket are added to it
  always_comb begin
    charge = '0;
    if (acl_valid_i && !acl_over && (inner_position_flag_i ? p3 : frame_valid_i)) begin
      charge[acl_bk] = 1'b1; // RULE_01
    end
    if (p1 && pp_ok && !over[bum_bk]) begin
      charge[bum_bk] = 1'b1;
    end
    if (p2 && sd_use && (sd_col == COL_GREEN)) begin
      charge[sd_bk] = 1'b1;
      charge[sd_bk + 1'b1] = cpl_reg[DL_W'(sd_idx)]; // RULE_20
    end
    if (p2 && sd_use && (sd_col == COL_YELLOW)) begin
      charge[sd_bk + 1'b1] = 1'b1;
    end
    if (p4 && bd_use && (bd_col == COL_GREEN)) begin
      charge[bd_bk] = 1'b1;
      charge[bd_bk + 1'b1] = cpl_reg[bd_dl]; // RULE_20
    end
    if (p4 && bd_use && (bd_col == COL_YELLOW)) begin
      charge[bd_bk + 1'b1] = 1'b1;
    end
    if (p5 && !over[port_bk]) begin
      charge[port_bk] = 1'b1;
    end
    if (p6 && storm_valid_i && !over[storm_bk]) begin
      charge[storm_bk] = 1'b1;
    end
  end

  // Verdict and service statistics
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      res_valid_o       <= 1'b0;
      res_drop_o        <= 1'b0;
      res_colour_o      <= 2'h0;
      svc_stat_valid_o  <= 1'b0;
      svc_stat_yellow_o <= 1'b0;
      svc_stat_red_o    <= 1'b0;
    end else begin
      res_valid_o       <= frame_valid_i;
      res_drop_o        <= frame_valid_i && !p7;
      res_colour_o      <= (frame_valid_i && !p7) ? COL_RED : fin_col;
      // Counted at the service stage, later drops do not change it
      svc_stat_valid_o  <= p2 && sd_use; // RULE_13
      svc_stat_yellow_o <= p2 && sd_use && (sd_col == COL_YELLOW); // RULE_13
      svc_stat_red_o    <= p2 && sd_use && (sd_col == COL_RED);
    end
  end

  // Flow control with hysteresis between the two thresholds
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      port_flow_ctrl_o <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!cfg1[PORT_B + p][FC_BIT]) begin
          port_flow_ctrl_o[p] <= 1'b0;
        end else if (over[PORT_B + p]) begin
          port_flow_ctrl_o[p] <= 1'b1; // RULE_17
        end else if (below2[PORT_B + p]) begin
          port_flow_ctrl_o[p] <= 1'b0; // RULE_17
        end
      end
    end
  end

  // Sticky flags: write one to clear, a new event in the same cycle wins
  logic [STK_W-1:0] stk_set;
  logic [2:0]       dstk_set;
  logic             sticky_wr, dlb_sticky_wr;

  assign stk_set[STK_ACL]   = outer_drop || inner_drop;
  assign stk_set[STK_BUM]   = bum_drop;
  assign stk_set[STK_PORT]  = port_drop;
  assign stk_set[STK_STORM] = storm_drop;
  assign stk_set[STK_FC]    = |(port_flow_ctrl_o);
  assign stk_set[STK_BUNDLE_DUAL_BUCKET]  = p4 && bd_use && (bd_col == COL_RED);
  assign dstk_set[0] = p2 && sd_use && (sd_col == COL_GREEN);
  assign dstk_set[1] = p2 && sd_use && (sd_col == COL_YELLOW);
  assign dstk_set[2] = p2 && sd_use && (sd_col == COL_RED);
  assign sticky_wr     = wr_i && (addr_i == ADDR_STICKY);
  assign dlb_sticky_wr = wr_i && (addr_i == ADDR_DLB_STICKY);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sticky_reg     <= '0;
      dlb_sticky_reg <= 3'h0;
    end else begin
      sticky_reg <= (sticky_reg & ~(sticky_wr ? wdata_i[STK_W-1:0] : '0)) | stk_set; // RULE_18
      dlb_sticky_reg <= (dlb_sticky_reg & ~(dlb_sticky_wr ? wdata_i[2:0] : 3'h0))
                      | dstk_set; // RULE_18
    end
  end

  // Global, service, port and dual-bucket tables
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= 2'h0;
      for (int s = 0; s < NUM_SERVICES; s++) begin
        svc_pp_reg[s] <= PP_NONE; // RULE_12
        svc_bd_reg[s] <= '0;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_q_reg[p]  <= '0;
        port_bd_reg[p] <= '0;
      end
      for (int d = 0; d < NUM_DLB; d++) begin
        cal_reg[d] <= CAL_RST; // RULE_19
        cpl_reg[d] <= 1'b0;
      end
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL) begin
        ctrl_reg <= wdata_i[1:0]; // RULE_09 RULE_11
      end
      for (int s = 0; s < NUM_SERVICES; s++) begin
        if (addr_i == ADDR_SVC_BASE + 10'(s)) begin
          svc_pp_reg[s] <= wdata_i[1:0];
          svc_bd_reg[s] <= wdata_i[SEL_B_LSB +: BD_W]; // RULE_10
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_i == ADDR_PORT_BASE + 10'(p)) begin
          port_q_reg[p]  <= wdata_i[SD_W-1:0];
          port_bd_reg[p] <= wdata_i[SEL_B_LSB +: BD_W];
        end
      end
      for (int d = 0; d < NUM_DLB; d++) begin
        if (addr_i == ADDR_DLB_BASE + 10'(d)) begin
          cal_reg[d] <= wdata_i[1:0];
          cpl_reg[d] <= wdata_i[CPL_BIT];
        end
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rd_data_o <= 32'h0000_0000;
      if (addr_i == ADDR_CTRL) begin
        rd_data_o <= 32'(ctrl_reg);
      end
      if (addr_i == ADDR_STICKY) begin
        rd_data_o <= 32'(sticky_reg);
      end
      if (addr_i == ADDR_DLB_STICKY) begin
        rd_data_o <= 32'(dlb_sticky_reg);
      end
      if (addr_i == ADDR_FC_STAT) begin
        rd_data_o <= 32'(port_flow_ctrl_o);
      end
      for (int s = 0; s < NUM_SERVICES; s++) begin
        if (addr_i == ADDR_SVC_BASE + 10'(s)) begin
          rd_data_o <= 32'(svc_pp_reg[s]) | (32'(svc_bd_reg[s]) << SEL_B_LSB);
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_i == ADDR_PORT_BASE + 10'(p)) begin
          rd_data_o <= 32'(port_q_reg[p]) | (32'(port_bd_reg[p]) << SEL_B_LSB);
        end
      end
      for (int d = 0; d < NUM_DLB; d++) begin
        if (addr_i == ADDR_DLB_BASE + 10'(d)) begin
          rd_data_o <= 32'(cal_reg[d]) | (32'(cpl_reg[d]) << CPL_BIT);
        end
      end
      for (int b = 0; b < NB; b++) begin
        if ((addr_i >= ADDR_BKT_BASE) && (bk_off[9:1] == 9'(b))) begin
          rd_data_o <= bk_off[0] ? cfg1[b] : cfg0[b];
        end
      end
    end
  end

endmodule : fph_policer
`default_nettype wire

/* src/fph_pkg.sv */
// Shared constants and types of the frame policer hierarchy
package fph_pkg;

  // Clock and rate steps
  localparam int CLK_HZ          = 50_000_000;
  localparam int SLB_STEP_BPS    = 25_040;
  localparam int FINE_STEP_BPS   = 16_000;
  localparam int COARSE_STEP_BPS = 8_000_000;
  // One rate unit drains one byte per tick
  localparam int SLB_TICK_CYC    = (CLK_HZ * 8) / SLB_STEP_BPS;
  localparam int FINE_TICK_CYC   = (CLK_HZ * 8) / FINE_STEP_BPS;
  localparam int COARSE_TICK_CYC = (CLK_HZ * 8) / COARSE_STEP_BPS;

  // Bucket config word 0
  localparam int RATE_LSB = 0;
  localparam int RATE_W   = 11;
  localparam int THR_LSB  = 11;
  localparam int THR_W    = 8;
  localparam int GAP_LSB  = 19;
  localparam int GAP_W    = 7;
  localparam int TS_BIT   = 26;
  localparam int EN_BIT   = 27;
  // Bucket config word 1
  localparam int THR2_LSB = 0;
  localparam int FC_BIT   = 8;
  // Thresholds count in 64 byte units
  localparam int THR_SHIFT = 6;
  localparam int FILL_W    = 20;
  localparam int LEN_W     = 14;

  // Register map, word addresses
  localparam logic [9:0] ADDR_CTRL       = 10'h000;
  localparam logic [9:0] ADDR_STICKY     = 10'h001;
  localparam logic [9:0] ADDR_DLB_STICKY = 10'h002;
  localparam logic [9:0] ADDR_FC_STAT    = 10'h003;
  localparam logic [9:0] ADDR_SVC_BASE   = 10'h010;
  localparam logic [9:0] ADDR_PORT_BASE  = 10'h040;
  localparam logic [9:0] ADDR_DLB_BASE   = 10'h080;
  localparam logic [9:0] ADDR_BKT_BASE   = 10'h100;

  // Control and table fields
  localparam int CTRL_DQ_BIT  = 0;
  localparam int CTRL_PB_BIT  = 1;
  localparam int SEL_B_LSB    = 8;
  localparam int CPL_BIT      = 2;
  localparam logic [1:0] PP_NONE  = 2'h0;
  localparam logic [1:0] CAL_RST  = 2'h3;

  // Sticky bit positions
  localparam int STK_ACL   = 0;
  localparam int STK_BUM   = 1;
  localparam int STK_PORT  = 2;
  localparam int STK_STORM = 3;
  localparam int STK_FC    = 4;
  localparam int STK_BUNDLE_DUAL_BUCKET  = 5;
  localparam int STK_W     = 6;

  typedef enum logic [1:0] {COL_GREEN, COL_YELLOW, COL_RED} fph_colour_type;

endpackage : fph_pkg

/* src/fph_bucket.sv */
// One leaky bucket with its own configuration words
`timescale 1ns/1ps
`default_nettype none
module fph_bucket
  import fph_pkg::*;
#(
  parameter bit SLB_MODE = 1'b1
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  // Drain enables
  input  wire logic             slb_tick_i,
  input  wire logic             fine_tick_i,
  input  wire logic             coarse_tick_i,
  // Configuration
  input  wire logic             wr_i,
  input  wire logic             wsel_i,
  input  wire logic [31:0]      wdata_i,
  output logic      [31:0]      cfg0_o,
  output logic      [31:0]      cfg1_o,
  // Metering
  input  wire logic             charge_i,
  input  wire logic [LEN_W-1:0] len_i,
  output logic                  over_o,
  output logic                  below2_o
);
  logic [31:0]       cfg0_reg;
  logic [31:0]       cfg1_reg;
  logic [FILL_W-1:0] fill_reg;
  logic [FILL_W-1:0] fill_next;
  logic              tick;
  logic [RATE_W-1:0] rate;
  logic signed [LEN_W+1:0] adj_len;
  logic [FILL_W-1:0] add_len;
  logic [FILL_W-1:0] thr_bytes;
  logic [FILL_W-1:0] thr2_bytes;

  assign cfg0_o = cfg0_reg;
  assign cfg1_o = cfg1_reg;
  assign rate   = cfg0_reg[RATE_LSB +: RATE_W];
  // Single buckets run on the fixed step, the others pick a timescale
  assign tick = SLB_MODE ? slb_tick_i :
                (cfg0_reg[TS_BIT] ? coarse_tick_i : fine_tick_i); // RULE_05 RULE_06 RULE_07
  // Signed gap correction, a negative result meters as zero
  assign adj_len = $signed({2'b00, len_i})
                 + (LEN_W+2)'($signed(cfg0_reg[GAP_LSB +: GAP_W])); // RULE_14
  assign add_len = adj_len[LEN_W+1] ? '0 : FILL_W'(adj_len[LEN_W:0]);
  assign thr_bytes  = FILL_W'({cfg0_reg[THR_LSB +: THR_W], THR_SHIFT'(0)});
  assign thr2_bytes = FILL_W'({cfg1_reg[THR2_LSB +: THR_W], THR_SHIFT'(0)});
  assign over_o   = cfg0_reg[EN_BIT] && (fill_reg > thr_bytes); // RULE_21
  assign below2_o = fill_reg <= thr2_bytes; // RULE_17

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg0_reg <= 32'h0000_0000;
      cfg1_reg <= 32'h0000_0000;
    end else if (wr_i) begin
      if (wsel_i) begin
        cfg1_reg <= wdata_i;
      end else begin
        cfg0_reg <= wdata_i;
      end
    end
  end

  always_comb begin
    fill_next = fill_reg;
    if (tick) begin
      fill_next = (fill_reg > FILL_W'(rate)) ? fill_reg - FILL_W'(rate) : '0; // RULE_21
    end
    // Saturate rather than wrap so a flood never looks like an empty bucket
    if (charge_i) begin
      fill_next = (fill_next > ~add_len) ? '1 : fill_next + add_len;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !cfg0_reg[EN_BIT]) begin
      fill_reg <= '0;
    end else begin
      fill_reg <= fill_next;
    end
  end

endmodule : fph_bucket
`default_nettype wire

/* testbench/fph_policer_checker.sv */
// Port-level assertions for the frame policer
`timescale 1ns/1ps
`default_nettype none
module fph_policer_checker
  import fph_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // Clock, reset and register port
  input wire logic                 mclk_i,
  input wire logic                 reset_i,
  input wire logic [9:0]           addr_i,
  input wire logic                 rd_i,
  input wire logic [31:0]          rd_data_o,
  // Frame in and verdict out
  input wire logic                 frame_valid_i,
  input wire logic                 res_valid_o,
  input wire logic                 res_drop_o,
  input wire logic [1:0]           res_colour_o,
  input wire logic                 svc_stat_valid_o,
  input wire logic                 svc_stat_yellow_o,
  input wire logic                 svc_stat_red_o,
  input wire logic [NUM_PORTS-1:0] port_flow_ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_verdict; frame_valid_i |=> res_valid_o; endproperty
  a_verdict: assert property (p_verdict) else $error("frame got no verdict");
  property p_no_spurious; res_valid_o |-> $past(frame_valid_i); endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("verdict without frame");
  property p_drop_red; res_valid_o && res_drop_o |-> res_colour_o == COL_RED; endproperty
  a_drop_red: assert property (p_drop_red) else $error("dropped frame not red");
  property p_drop_valid; res_drop_o |-> res_valid_o; endproperty
  a_drop_valid: assert property (p_drop_valid) else $error("drop outside verdict");
  property p_stat_valid; svc_stat_valid_o |-> res_valid_o; endproperty
  a_stat_valid: assert property (p_stat_valid) else $error("service stat without verdict");
  property p_stat_col; svc_stat_yellow_o || svc_stat_red_o |-> svc_stat_valid_o && !(svc_stat_yellow_o && svc_stat_red_o);
  endproperty
  a_stat_col: assert property (p_stat_col) else $error("bad service colour");
  property p_unmapped; rd_i && addr_i == 10'h3ff |=> rd_data_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset; disable iff (1'b0) reset_i |=> !res_valid_o && port_flow_ctrl_o == '0; endproperty
  a_reset: assert property (p_reset) else $error("outputs live in reset");
endmodule : fph_policer_checker
bind fph_policer fph_policer_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);
`default_nettype wire

/* testbench/fph_pipe_model.sv */
// Classifier pipeline model that presents frames to the policer
`timescale 1ns/1ps
`default_nettype none
module fph_pipe_model (
  input wire logic  mclk_i,
  output logic        frame_valid_i, acl_valid_i, storm_valid_i, inner_position_flag_i,
  output logic [13:0] frame_len_i,
  output logic [1:0]  frame_port_i, frame_dp_i, frame_cast_i, frame_stage_i,
  output logic [2:0]  service_index_i, service_policer_index_i, storm_index_i,
  output logic [4:0]  acl_index_i
);
  initial begin
    {frame_valid_i, acl_valid_i, storm_valid_i, inner_position_flag_i, frame_len_i} = '0;
    {frame_port_i, frame_dp_i, frame_cast_i, frame_stage_i} = '0;
    {service_index_i, service_policer_index_i, storm_index_i, acl_index_i} = '0;
  end
  // Fields qualify only the pulse cycle; afterwards the length shows garbage
  task send(input logic av, input logic sv, input logic [4:0] idx, input logic [13:0] len);
    @(posedge mclk_i);
    frame_valid_i <= 1'b1;
    acl_valid_i   <= av;
    storm_valid_i <= sv;
    acl_index_i   <= idx;
    storm_index_i <= idx[2:0];
    frame_len_i   <= len;
    @(posedge mclk_i);
    frame_valid_i <= 1'b0;
    frame_len_i   <= ~len;
  endtask : send
endmodule : fph_pipe_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the frame policer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fph_pkg::*;
  logic        mclk_i, reset_i, wr_i, rd_i, frame_valid_i, acl_valid_i, storm_valid_i, inner_position_flag_i;
  logic        res_valid_o, res_drop_o, svc_stat_valid_o, svc_stat_yellow_o, svc_stat_red_o;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i, rd_data_o, d;
  logic [13:0] frame_len_i;
  logic [1:0]  frame_port_i, frame_dp_i, frame_cast_i, frame_stage_i, res_colour_o;
  logic [2:0]  service_index_i, service_policer_index_i, storm_index_i;
  logic [4:0]  acl_index_i;
  logic [3:0]  port_flow_ctrl_o;
  int          errors, n_checks, cyc;
  // Row: acl valid, storm valid, index, expected drop; every frame is 100 bytes
  logic [7:0]  rows [7] = '{8'h80, 8'h81, 8'hbe, 8'hbe, 8'hbf, 8'h4e, 8'h4f};
  fph_policer #(.SLB_TICK_CYCLES(20), .FINE_TICK_CYCLES(30)) uut (.*);
  fph_pipe_model u_pipe (.*);
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a);
    @(posedge mclk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd
  task frame(input logic [7:0] r);
    u_pipe.send(r[7], r[6], r[5:1], 14'd100);
    #1;
    chk("res_valid", 32'h1, {31'h0, res_valid_o});
    chk("res_drop", {31'h0, r[0]}, {31'h0, res_drop_o});
    chk("colour", r[0] ? COL_RED : COL_GREEN, {30'h0, res_colour_o});
  endtask : frame
  task complete_run;
    if (errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 44'h0};
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 chk("reset flow", 32'h0, {28'h0, port_flow_ctrl_o});
    rd(ADDR_CTRL);
    chk("ctrl reset", 32'h0, d);
    rd(10'h3ff);
    chk("unmapped", 32'h0, d);
    // Rate zero stops the drain, so only charges move the fill while the rows run
    wr(10'h100, 32'h0800_0800);
    wr(10'h13e, 32'h0a00_0800);
    wr(10'h14e, 32'h0800_0800);
    for (int i = 0; i < 7; i++) frame(rows[i]);
    rd(ADDR_STICKY);
    chk("sticky", 32'h9, d);
    wr(ADDR_STICKY, 32'h3f);
    rd(ADDR_STICKY);
    chk("sticky clr", 32'h0, d);
    wr(10'h100, 32'h0800_0fff);
    repeat (25) @(posedge mclk_i);
    frame(8'h80);
    frame(8'h81);
    // Default queue policing meters a non-service frame on service policer zero
    wr(ADDR_CTRL, 32'h1);
    frame(8'h00);
    chk("svc stat", 32'h1, {31'h0, svc_stat_valid_o});
    rd(ADDR_DLB_STICKY);
    chk("svc sticky", 32'h1, d);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
